// File: src/dls_pkg.sv
// Shared constants and types for the 21-to-3 display link serializer
package dls_pkg;

  // ****************************************
  // Word and lane geometry
  // ****************************************
  localparam int DATA_W = 21;
  localparam int LANES = 3;
  localparam int SLICE = 7;
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 3'h6;
  localparam logic [PHASE_W-1:0] CLK_HIGH_SLOTS = 3'h4;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0] WORD_RST = 21'h000000;
  localparam logic [LANES:0] LANE_OFF = 4'hF;
  localparam logic [LANES:0] LANE_ON = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_SYS_MHZ = 20;
  localparam int LOCK_TIME_NS = 1000000;
  localparam int LOCK_CYC = (LOCK_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int DIS_TIME_NS = 250;
  localparam int DIS_CYC_RAW = (DIS_TIME_NS * CLK_SYS_MHZ) / 1000;
  localparam int DIS_CYC = (DIS_CYC_RAW < 1) ? 1 : DIS_CYC_RAW;

  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [2:0] {
    LK_OFF = 3'b001,
    LK_ACQ = 3'b010,
    LK_ON = 3'b100
  } dls_lock_t;

  typedef enum logic [1:0] {
    SND_IDLE = 2'b01,
    SND_BUSY = 2'b10
  } dls_send_t;

endpackage

// File: src/dls_serializer.sv
// Display link serializer: pixel capture, word FIFO, crossing and 7:1 lane shifter

// ****************************************
// Word FIFO
// ****************************************
module dls_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign wr_ready_o = (cnt_reg != FULL_CNT);
  assign rd_valid_o = (cnt_reg != '0);
  assign rd_data_o = mem[rp_reg];
  assign push = wr_valid_i & wr_ready_o;
  assign pop = rd_valid_o & rd_ready_i;

  // Power-down wipes stored words too, not only the pointers
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (push) begin
      mem[wp_reg] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ****************************************
// Serializer top
// ****************************************
module dls_serializer #(
  parameter int LOCK_CYCLES = dls_pkg::LOCK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clk_link_i,
  input wire logic pixel_clock_in_i,
  input wire logic [dls_pkg::DATA_W-1:0] parallel_pixel_bits_i,
  input wire logic power_down_n_i,
  output logic pixel_ready_o,
  output logic locked_o,
  output logic [dls_pkg::LANES-1:0] serial_lane_o,
  output logic link_clock_out_o,
  output logic [dls_pkg::LANES:0] lane_oe_n_o
);
  import dls_pkg::*;

  localparam int LCW = $clog2(LOCK_CYCLES + 1);
  localparam int DIS_BOUND = DIS_CYC;

  // ****************************************
  // System domain: input synchronisers
  // ****************************************
  logic pd_meta_reg;
  logic pd_sync_reg;
  logic pclk_meta_reg;
  logic pclk_sync_reg;
  logic pclk_last_reg;
  logic [DATA_W-1:0] data_meta_reg;
  logic [DATA_W-1:0] data_sync_reg;
  logic [DATA_W-1:0] hold_reg;
  logic cap_vld_reg;
  logic sys_clr;
  logic pclk_fall;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pd_meta_reg <= 1'b0;
      pd_sync_reg <= 1'b0;
      pclk_meta_reg <= 1'b0;
      pclk_sync_reg <= 1'b0;
      data_meta_reg <= WORD_RST;
      data_sync_reg <= WORD_RST;
    end else begin
      pd_meta_reg <= power_down_n_i;
      pd_sync_reg <= pd_meta_reg;
      pclk_meta_reg <= pixel_clock_in_i;
      pclk_sync_reg <= pclk_meta_reg;
      data_meta_reg <= parallel_pixel_bits_i;
      data_sync_reg <= data_meta_reg;
    end
  end

  assign sys_clr = sys_rst_i | ~pd_sync_reg;
  assign pclk_fall = pclk_last_reg & ~pclk_sync_reg;

  // ****************************************
  // System domain: lock sequencer
  // ****************************************
  dls_lock_t lk_state_reg;
  logic [LCW-1:0] lk_cnt_reg;

  // Lane data stays off until the full lock time has elapsed
  always_ff @(posedge clk_sys_i) begin
    if (sys_clr) begin
      lk_state_reg <= LK_OFF;
      lk_cnt_reg <= '0;
    end else begin
      case (lk_state_reg)
        LK_OFF: begin
          lk_state_reg <= LK_ACQ;
          lk_cnt_reg <= '0;
        end
        LK_ACQ: begin
          if (lk_cnt_reg == LCW'(LOCK_CYCLES - 1)) begin
            lk_state_reg <= LK_ON;
          end else begin
            lk_cnt_reg <= lk_cnt_reg + 1'b1;
          end
        end
        LK_ON: begin
          lk_state_reg <= LK_ON;
        end
        default: begin
          lk_state_reg <= LK_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_clr) begin
      locked_o <= 1'b0;
    end else begin
      locked_o <= (lk_state_reg == LK_ON);
    end
  end

  // ****************************************
  // System domain: capture into FIFO
  // ****************************************
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [DATA_W-1:0] fifo_rd_data;

  always_ff @(posedge clk_sys_i) begin
    if (sys_clr) begin
      pclk_last_reg <= 1'b0;
      hold_reg <= WORD_RST;
      cap_vld_reg <= 1'b0;
      pixel_ready_o <= 1'b0;
    end else begin
      pclk_last_reg <= pclk_sync_reg;
      if (pclk_fall) begin
        hold_reg <= data_sync_reg;
      end
      cap_vld_reg <= pclk_fall & pixel_ready_o;
      pixel_ready_o <= locked_o & fifo_wr_ready;
    end
  end

  dls_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_sys_i),
    .clr_i(sys_clr),
    .wr_valid_i(cap_vld_reg),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(hold_reg),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  // ****************************************
  // System domain: toggle handshake sender
  // ****************************************
  dls_send_t snd_state_reg;
  logic [DATA_W-1:0] xfer_data_reg;
  logic req_tog_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic ack_tog_reg;

  assign fifo_rd_ready = (snd_state_reg == SND_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (sys_clr) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ack_tog_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // Data word is held stable until the link side acknowledges it
  always_ff @(posedge clk_sys_i) begin
    if (sys_clr) begin
      snd_state_reg <= SND_IDLE;
      xfer_data_reg <= WORD_RST;
      req_tog_reg <= 1'b0;
    end else begin
      case (snd_state_reg)
        SND_IDLE: begin
          if (fifo_rd_valid) begin
            xfer_data_reg <= fifo_rd_data;
            req_tog_reg <= ~req_tog_reg;
            snd_state_reg <= SND_BUSY;
          end
        end
        SND_BUSY: begin
          if (ack_sync_reg == req_tog_reg) begin
            snd_state_reg <= SND_IDLE;
          end
        end
        default: begin
          snd_state_reg <= SND_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Link domain: synchronisers
  // ****************************************
  logic lrst_meta_reg;
  logic lrst_sync_reg;
  logic lpd_meta_reg;
  logic lpd_sync_reg;
  logic lgo_meta_reg;
  logic lgo_sync_reg;
  logic lreq_meta_reg;
  logic lreq_sync_reg;
  logic l_clr;

  // Power-down takes its own short path so the off state is not held
  // back by the slower system-side lock sequencer
  always_ff @(posedge clk_link_i) begin
    lrst_meta_reg <= sys_rst_i;
    lrst_sync_reg <= lrst_meta_reg;
    lpd_meta_reg <= power_down_n_i;
    lpd_sync_reg <= lpd_meta_reg;
    lgo_meta_reg <= locked_o;
    lgo_sync_reg <= lgo_meta_reg;
    lreq_meta_reg <= req_tog_reg;
    lreq_sync_reg <= lreq_meta_reg;
  end

  assign l_clr = lrst_sync_reg | ~lpd_sync_reg | ~lgo_sync_reg;

  // ****************************************
  // Link domain: word receiver
  // ****************************************
  logic lreq_seen_reg;
  logic pend_reg;
  logic [DATA_W-1:0] pend_data_reg;
  logic [DATA_W-1:0] word_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic frame_end;

  assign frame_end = (phase_reg == PHASE_LAST);

  always_ff @(posedge clk_link_i) begin
    if (l_clr) begin
      lreq_seen_reg <= lreq_sync_reg;
      pend_reg <= 1'b0;
      pend_data_reg <= WORD_RST;
      ack_tog_reg <= 1'b0;
    end else begin
      if (frame_end && pend_reg) begin
        pend_reg <= 1'b0;
        ack_tog_reg <= ~ack_tog_reg;
      end else if (!pend_reg && (lreq_sync_reg != lreq_seen_reg)) begin
        pend_reg <= 1'b1;
        pend_data_reg <= xfer_data_reg;
        lreq_seen_reg <= lreq_sync_reg;
      end
    end
  end

  // ****************************************
  // Link domain: slot counter and link clock
  // ****************************************
  always_ff @(posedge clk_link_i) begin
    if (l_clr) begin
      phase_reg <= PHASE_LAST;
      link_clock_out_o <= 1'b0;
      lane_oe_n_o <= LANE_OFF;
    end else begin
      phase_reg <= frame_end ? '0 : phase_reg + 1'b1;
      link_clock_out_o <= frame_end | (phase_reg < (CLK_HIGH_SLOTS - 1'b1));
      lane_oe_n_o <= LANE_ON;
    end
  end

  // ****************************************
  // Link domain: lane shifters
  // ****************************************
  // Idle frames repeat the last word rather than inserting fill patterns
  always_ff @(posedge clk_link_i) begin
    if (l_clr) begin
      word_reg <= WORD_RST;
    end else if (frame_end && pend_reg) begin
      word_reg <= pend_data_reg;
    end
  end

  logic [DATA_W-1:0] load_word;
  assign load_word = pend_reg ? pend_data_reg : word_reg;

  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      logic [SLICE-2:0] sh_reg;
      always_ff @(posedge clk_link_i) begin
        if (l_clr) begin
          sh_reg <= '0;
          serial_lane_o[gl] <= 1'b0;
        end else if (frame_end) begin
          serial_lane_o[gl] <= load_word[gl*SLICE];
          sh_reg <= load_word[gl*SLICE+1 +: SLICE-1];
        end else begin
          serial_lane_o[gl] <= sh_reg[0];
          sh_reg <= {1'b0, sh_reg[SLICE-2:1]};
        end
      end
    end
  endgenerate

  // ****************************************
  // Checks: system domain
  // ****************************************
  a_capture_on_fall: assert property (@(posedge clk_sys_i) disable iff (sys_clr)
    pclk_fall |=> hold_reg == $past(data_sync_reg))
    else $error("pixel word not captured on falling edge");

  a_pd_clears_all: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !pd_sync_reg |=> hold_reg == '0 && lk_state_reg == LK_OFF && !locked_o)
    else $error("power-down did not clear system registers");

  a_lock_after_wait: assert property (@(posedge clk_sys_i) disable iff (sys_clr)
    $rose(locked_o) |-> $past(lk_cnt_reg, 2) == LCW'(LOCK_CYCLES - 1))
    else $error("lock reported before lock time elapsed");

  a_disable_time: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(pd_sync_reg) |-> ##[0:DIS_BOUND] !link_clock_out_o)
    else $error("link clock not low within disable time");

  c_word_sent: cover property (@(posedge clk_sys_i) disable iff (sys_clr)
    snd_state_reg == SND_BUSY ##1 snd_state_reg == SND_IDLE);

  c_fifo_full: cover property (@(posedge clk_sys_i) disable iff (sys_clr)
    locked_o && !fifo_wr_ready);

  c_pd_while_locked: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    locked_o ##1 !pd_sync_reg);

  // ****************************************
  // Checks: link domain
  // ****************************************
  a_clk_four_high: assert property (@(posedge clk_link_i) disable iff (l_clr)
    $rose(link_clock_out_o) |-> link_clock_out_o [*4] ##1 !link_clock_out_o [*3]
      ##1 link_clock_out_o)
    else $error("link clock shape is not four high three low");

  a_bit0_at_rise: assert property (@(posedge clk_link_i) disable iff (l_clr)
    $rose(link_clock_out_o) |-> phase_reg == '0)
    else $error("bit position zero not at link clock rise");

  a_lane_shift: assert property (@(posedge clk_link_i) disable iff (l_clr)
    !$past(frame_end) && !$past(l_clr) |-> serial_lane_o[0] == $past(g_lane[0].sh_reg[0])
      && serial_lane_o[2] == $past(g_lane[2].sh_reg[0]))
    else $error("lane bit does not follow shift register");

  a_slice_map: assert property (@(posedge clk_link_i) disable iff (l_clr)
    frame_end && pend_reg |=> serial_lane_o[0] == $past(pend_data_reg[0])
      && serial_lane_o[1] == $past(pend_data_reg[7])
      && serial_lane_o[2] == $past(pend_data_reg[14])
      ##6 serial_lane_o[2] == $past(pend_data_reg[20], 7))
    else $error("slice mapping to lanes is wrong");

  a_off_in_pd: assert property (@(posedge clk_link_i) disable iff (lrst_sync_reg)
    !lpd_sync_reg |=> !link_clock_out_o && lane_oe_n_o == LANE_OFF
      && serial_lane_o == '0 && word_reg == '0)
    else $error("link not off during power-down");

  c_link_frame: cover property (@(posedge clk_link_i) disable iff (l_clr)
    frame_end && pend_reg);

endmodule

// File: test/dls_rx_model.sv
// Behavioural link receiver that rebuilds words from the lanes and link clock
module dls_rx_model (
  input wire logic clk_link_i,
  input wire logic link_clock_out_i,
  input wire logic [dls_pkg::LANES-1:0] serial_lane_i,
  input wire logic [dls_pkg::LANES:0] lane_oe_n_i,
  output logic [dls_pkg::DATA_W-1:0] word_o,
  output int hi_len_o,
  output int lo_len_o
);
  import dls_pkg::*;
  // ****************************************
  // Mid-bit sampling on the falling bit clock edge
  // ****************************************
  logic clk_prev = 1'b0;
  logic [DATA_W-1:0] shf = WORD_RST;
  int slot = SLICE;
  int hi_cnt = 0;
  int lo_cnt = 0;

  initial word_o = WORD_RST;
  initial hi_len_o = 0;
  initial lo_len_o = 0;

  always @(negedge clk_link_i) begin
    if (link_clock_out_i && !clk_prev) begin
      slot = 0;
      hi_cnt = 0;
      lo_len_o = lo_cnt;
    end
    if (!link_clock_out_i && clk_prev) begin
      hi_len_o = hi_cnt;
      lo_cnt = 0;
    end
    if (link_clock_out_i) hi_cnt++;
    else lo_cnt++;
    // Drivers switched off means nothing valid on the lanes
    if (slot < SLICE && lane_oe_n_i === LANE_ON) begin
      for (int k = 0; k < LANES; k++) shf[SLICE*k+slot] = serial_lane_i[k];
      if (slot == SLICE - 1) word_o = shf;
      slot++;
    end
    clk_prev = link_clock_out_i;
  end
endmodule

// File: test/dls_serializer_tb.sv
// Self-checking bench for the display link serializer
module dls_serializer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dls_pkg::*;
  // ****************************************
  // Clocks, design and receiver model
  // ****************************************
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pix_clk = 1'b0;
  logic [DATA_W-1:0] pix_data = WORD_RST;
  logic power_down_n = 1'b1;
  logic link_run = 1'b1;
  logic pixel_ready, locked, link_clk;
  logic [LANES-1:0] lanes;
  logic [LANES:0] oe_n;
  logic [DATA_W-1:0] rx_word, last_rx, w;
  logic [31:0] lfsr = 32'h000155DD;
  logic ready_low;
  logic [DATA_W-1:0] rxq[$];
  logic [DATA_W-1:0] sent[$];
  int hi_len, lo_len, j;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  initial forever #25 clk_sys_i = ~clk_sys_i;
  initial begin
    #3.7;
    // Stopping the bit clock stalls the link so that the FIFO can fill
    forever #7.5 clk_link_i = link_run & ~clk_link_i;
  end

  dls_serializer #(.LOCK_CYCLES(20)) dls_serializer_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_link_i(clk_link_i),
    .pixel_clock_in_i(pix_clk), .parallel_pixel_bits_i(pix_data),
    .power_down_n_i(power_down_n), .pixel_ready_o(pixel_ready), .locked_o(locked),
    .serial_lane_o(lanes), .link_clock_out_o(link_clk), .lane_oe_n_o(oe_n));

  dls_rx_model dls_rx_model_i (
    .clk_link_i(clk_link_i), .link_clock_out_i(link_clk), .serial_lane_i(lanes),
    .lane_oe_n_i(oe_n), .word_o(rx_word), .hi_len_o(hi_len), .lo_len_o(lo_len));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Transparent link: the receiver must show exactly the word given
  function automatic logic [DATA_W-1:0] exp_word(input logic [DATA_W-1:0] x);
    return x;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #5;
  endtask

  // Pixel clock high 4 and low 3 cycles keeps the duty inside the allowed band;
  // the word settles only after the rise, so a rising-edge capture takes its inverse
  task automatic send_word(input logic [DATA_W-1:0] x);
    pix_clk = 1'b1;
    pix_data = ~x;
    tick(2);
    pix_data = x;
    tick(2);
    pix_clk = 1'b0;
    tick(3);
  endtask

  task automatic wait_word(input logic [DATA_W-1:0] x);
    int n;
    n = 0;
    while (rx_word !== x && n < 400) begin
      tick(1);
      n++;
    end
    check("rx word", rx_word, exp_word(x));
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (pixel_ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check("pixel ready", pixel_ready, 1'b1);
  endtask

  task automatic check_off();
    check("link clock", link_clk, 1'b0);
    check("lane enables", oe_n, LANE_OFF);
    check("lanes", lanes, 3'h0);
    check("locked", locked, 1'b0);
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  always @(posedge clk_sys_i) begin
    if (rx_word !== last_rx) begin
      rxq.push_back(rx_word);
      last_rx = rx_word;
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    last_rx = WORD_RST;
    tick(10);
    check_off();
    tick(6);
    sys_rst_i = 1'b0;
    tick(15);
    check("locked early", locked, 1'b0);
    wait_ready();
    wait_word(WORD_RST);
    check("lane enables on", oe_n, LANE_ON);
    for (int i = 0; i < 25; i++) begin
      case (i)
        0: w = 21'h1FFFFF;
        1: w = 21'h000001;
        2: w = 21'h100000;
        3: w = 21'h0AAAAA;
        4: w = 21'h155555;
        default: begin
          lfsr = lfsr_next(lfsr);
          w = lfsr[DATA_W-1:0];
        end
      endcase
      send_word(w);
      wait_word(w);
    end
    check("clock high slots", hi_len, CLK_HIGH_SLOTS);
    check("clock low slots", lo_len, SLICE - CLK_HIGH_SLOTS);
    // With the bit clock stalled, back-to-back words must fill the FIFO until it refuses
    rxq.delete();
    ready_low = 1'b0;
    link_run = 1'b0;
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      if (pixel_ready === 1'b1) sent.push_back(lfsr[DATA_W-1:0]);
      else ready_low = 1'b1;
      send_word(lfsr[DATA_W-1:0]);
    end
    link_run = 1'b1;
    tick(300);
    check("fifo refused", ready_low, 1'b1);
    check("burst count", rxq.size() >= FIFO_DEPTH, 1'b1);
    j = 0;
    foreach (rxq[i]) begin
      while (j < sent.size() && sent[j] !== rxq[i]) j++;
      check("burst order", j < sent.size(), 1'b1);
      j++;
    end
    // Power-down with a word still in flight
    lfsr = lfsr_next(lfsr);
    send_word(lfsr[DATA_W-1:0]);
    power_down_n = 1'b0;
    tick(5);
    check_off();
    check("ready off", pixel_ready, 1'b0);
    tick(10);
    check("clock stopped", link_clk, 1'b0);
    power_down_n = 1'b1;
    tick(15);
    check("relock early", locked, 1'b0);
    wait_ready();
    wait_word(WORD_RST);
    check("lane enables again", oe_n, LANE_ON);
    send_word(21'h123456);
    wait_word(21'h123456);
    final_report();
  end
endmodule
